// *** verilog/pss_pkg.sv ***
`default_nettype none

package pss_pkg;

    // -----------------------------------------------------------------
    // Timing figures, derived cycle counts and counter widths.
    // -----------------------------------------------------------------
    localparam int unsigned CLK_MHZ        = 40;
    localparam int unsigned BUS_RATE_KBPS  = 400;
    localparam int unsigned STRETCH_MAX_US = 1000;
    localparam int unsigned SCL_TIMEOUT_US = 25000;
    localparam int unsigned STRETCH_CYC    = STRETCH_MAX_US * CLK_MHZ;
    localparam int unsigned TIMEOUT_CYC    = SCL_TIMEOUT_US * CLK_MHZ + 1;
    localparam int unsigned STR_W          = 16;
    localparam int unsigned LOW_W          = 20;

    // -----------------------------------------------------------------
    // Target addresses, memory size and transfer limits.
    // -----------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL_BASE = 8'hB0;
    localparam logic [7:0]  ADDR_EE_BASE   = 8'hA0;
    localparam int unsigned EE_BYTES       = 256;
    localparam logic [7:0]  BLOCK_MAX      = 8'hFF;
    localparam logic [7:0]  RD_FILL        = 8'hFF;

    // -----------------------------------------------------------------
    // Types.
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE     = 3'b000,
        S_RECV     = 3'b001,
        S_RECV_END = 3'b010,
        S_ACK      = 3'b011,
        S_SEND     = 3'b100,
        S_SACK     = 3'b101,
        S_SNXT     = 3'b110,
        S_RDWAIT   = 3'b111
    } pss_state_type;

    typedef struct packed {
        logic       start;
        logic       is_read;
        logic       cmd_valid;
        logic [7:0] cmd;
        logic       wr_valid;
        logic [7:0] wr_data;
        logic [7:0] count;
        logic       rd_req;
        logic       stop;
        logic       abort;
    } pss_ctrl_out_type;

    typedef struct packed {
        logic             scl_m;
        logic             scl_s;
        logic             scl_d;
        logic             sda_m;
        logic             sda_s;
        logic             sda_d;
        logic [2:0]       strap_m;
        logic [2:0]       strap_s;
        pss_state_type    state;
        logic [2:0]       bitcnt;
        logic [7:0]       shift;
        logic             is_addr;
        logic             tgt_ctrl;
        logic             rd;
        logic             first;
        logic [7:0]       ptr;
        logic [7:0]       wcnt;
        logic [7:0]       rcnt;
        logic             ctrl_act;
        logic             sda_oe;
        logic             scl_oe;
        logic             sda_o;
        logic             scl_o;
        logic [STR_W-1:0] str_cnt;
        logic [LOW_W-1:0] low_cnt;
        pss_ctrl_out_type ctrl;
    } pss_regs_type;

    localparam pss_regs_type REGS_RST = '0;

endpackage : pss_pkg

`default_nettype wire

// *** verilog/pss_slave.sv ***
`timescale 1ns/1ps
`default_nettype none

module pss_slave #(
    parameter int unsigned STRETCH_CYC = pss_pkg::STRETCH_CYC,
    parameter int unsigned TIMEOUT_CYC = pss_pkg::TIMEOUT_CYC
) (
    input  wire logic                      I_SYS_CLK,
    input  wire logic                      I_NRST,
    input  wire logic                      I_SCL,
    output var  logic                      O_SCL_OUT,
    output var  logic                      O_SCL_OE,
    input  wire logic                      I_SDA,
    output var  logic                      O_SDA_OUT,
    output var  logic                      O_SDA_OE,
    input  wire logic                      I_ADDR_STRAP_BIT0,
    input  wire logic                      I_ADDR_STRAP_BIT1,
    input  wire logic                      I_ADDR_STRAP_BIT2,
    input  wire logic                      I_CTRL_RD_VALID,
    input  wire logic [7:0]                I_CTRL_RD_DATA,
    output var  pss_pkg::pss_ctrl_out_type O_CTRL
);
    import pss_pkg::*;

    // -----------------------------------------------------------------
    // State and memory.
    // -----------------------------------------------------------------
    pss_regs_type r_reg;
    pss_regs_type r_next;
    logic [7:0]   mem [EE_BYTES];
    logic         mem_we;
    logic [7:0]   mem_addr;
    logic [7:0]   mem_data;
    logic         scl_rise;
    logic         scl_fall;
    logic         start_det;
    logic         stop_det;
    logic         timeout;
    logic         clean;
    logic         hit_ctrl;
    logic         hit_ee;
    logic [7:0]   ee_rd;

    assign scl_rise  = r_reg.scl_s & ~r_reg.scl_d;
    assign scl_fall  = ~r_reg.scl_s & r_reg.scl_d;
    assign start_det = r_reg.scl_s & r_reg.scl_d & r_reg.sda_d & ~r_reg.sda_s;
    assign stop_det  = r_reg.scl_s & r_reg.scl_d & ~r_reg.sda_d & r_reg.sda_s;
    assign timeout   = ~r_reg.scl_s
                       && (r_reg.low_cnt == LOW_W'(TIMEOUT_CYC - 1));
    // A START or STOP between bytes comes after one sampled clock rise.
    assign clean     = (r_reg.state == S_IDLE)
                       || ((r_reg.state == S_RECV) && (r_reg.bitcnt <= 3'h1));
    assign hit_ctrl  = {r_reg.shift[7:1], 1'b0}
                       == (ADDR_CTRL_BASE | {4'h0, r_reg.strap_s, 1'b0});
    assign hit_ee    = {r_reg.shift[7:1], 1'b0}
                       == (ADDR_EE_BASE | {4'h0, r_reg.strap_s, 1'b0});
    assign ee_rd     = mem[r_reg.ptr];

    // -----------------------------------------------------------------
    // Next state.
    // -----------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        mem_we = 1'b0;
        mem_addr = r_reg.ptr;
        mem_data = r_reg.shift;
        // Two flip-flops on every bus and strap pin before any logic looks at it.
        r_next.scl_m = I_SCL;
        r_next.scl_s = r_reg.scl_m;
        r_next.scl_d = r_reg.scl_s;
        r_next.sda_m = I_SDA;
        r_next.sda_s = r_reg.sda_m;
        r_next.sda_d = r_reg.sda_s;
        r_next.strap_m = {I_ADDR_STRAP_BIT2, I_ADDR_STRAP_BIT1, I_ADDR_STRAP_BIT0};
        r_next.strap_s = r_reg.strap_m;
        r_next.sda_o = 1'b0;
        r_next.scl_o = 1'b0;
        r_next.ctrl.start = 1'b0;
        r_next.ctrl.cmd_valid = 1'b0;
        r_next.ctrl.wr_valid = 1'b0;
        r_next.ctrl.rd_req = 1'b0;
        r_next.ctrl.stop = 1'b0;
        r_next.ctrl.abort = 1'b0;
        if (r_reg.scl_s) begin
            r_next.low_cnt = '0;
        end else if (!timeout) begin
            r_next.low_cnt = r_reg.low_cnt + LOW_W'(1);
        end
        if (timeout) begin
            // Return to idle at once, well inside the recovery limit.
            r_next.state = S_IDLE;
            r_next.sda_oe = 1'b0;
            r_next.scl_oe = 1'b0;
            r_next.ctrl.abort = r_reg.ctrl_act;
            r_next.ctrl_act = 1'b0;
        end else if (start_det) begin
            r_next.state = S_RECV;
            r_next.is_addr = 1'b1;
            r_next.bitcnt = 3'h0;
            r_next.sda_oe = 1'b0;
            r_next.scl_oe = 1'b0;
            r_next.ctrl.abort = r_reg.ctrl_act & ~clean;
            r_next.ctrl_act = r_reg.ctrl_act & clean;
        end else if (stop_det) begin
            r_next.state = S_IDLE;
            r_next.sda_oe = 1'b0;
            r_next.scl_oe = 1'b0;
            r_next.ctrl.stop = r_reg.ctrl_act & clean;
            r_next.ctrl.abort = r_reg.ctrl_act & ~clean;
            r_next.ctrl_act = 1'b0;
        end else begin
            unique case (r_reg.state)
                S_IDLE: begin
                end
                S_RECV: begin
                    if (scl_rise) begin
                        r_next.shift = {r_reg.shift[6:0], r_reg.sda_s};
                        r_next.bitcnt = r_reg.bitcnt + 3'h1;
                        if (r_reg.bitcnt == 3'h7) begin
                            r_next.state = S_RECV_END;
                        end
                    end
                end
                S_RECV_END: begin
                    if (scl_fall) begin
                        r_next.state = S_ACK;
                        r_next.sda_oe = 1'b1;
                        if (r_reg.is_addr) begin
                            r_next.is_addr = 1'b0;
                            r_next.rd = r_reg.shift[0];
                            r_next.tgt_ctrl = hit_ctrl;
                            r_next.first = 1'b1;
                            r_next.wcnt = 8'h00;
                            r_next.rcnt = 8'h00;
                            if (hit_ctrl) begin
                                r_next.ctrl_act = 1'b1;
                                r_next.ctrl.start = 1'b1;
                                r_next.ctrl.is_read = r_reg.shift[0];
                            end else if (!hit_ee) begin
                                r_next.state = S_IDLE;
                                r_next.sda_oe = 1'b0;
                            end
                        end else if (r_reg.tgt_ctrl) begin
                            if (r_reg.wcnt == BLOCK_MAX) begin
                                r_next.state = S_IDLE;
                                r_next.sda_oe = 1'b0;
                            end else begin
                                r_next.wcnt = r_reg.wcnt + 8'h01;
                                r_next.ctrl.count = r_reg.wcnt + 8'h01;
                                if (r_reg.wcnt == 8'h00) begin
                                    r_next.ctrl.cmd_valid = 1'b1;
                                    r_next.ctrl.cmd = r_reg.shift;
                                end else begin
                                    r_next.ctrl.wr_valid = 1'b1;
                                    r_next.ctrl.wr_data = r_reg.shift;
                                end
                            end
                        end else if (r_reg.first) begin
                            r_next.first = 1'b0;
                            r_next.ptr = r_reg.shift;
                        end else begin
                            mem_we = 1'b1;
                            r_next.ptr = r_reg.ptr + 8'h01;
                        end
                    end
                end
                S_ACK, S_SNXT: begin
                    if (scl_fall) begin
                        r_next.sda_oe = 1'b0;
                        r_next.bitcnt = 3'h0;
                        if (!r_reg.rd) begin
                            r_next.state = S_RECV;
                        end else if (!r_reg.tgt_ctrl) begin
                            r_next.shift = ee_rd;
                            r_next.sda_oe = ~ee_rd[7];
                            r_next.ptr = r_reg.ptr + 8'h01;
                            r_next.state = S_SEND;
                        end else if (r_reg.rcnt == BLOCK_MAX) begin
                            r_next.shift = RD_FILL;
                            r_next.state = S_SEND;
                        end else begin
                            r_next.rcnt = r_reg.rcnt + 8'h01;
                            r_next.ctrl.rd_req = 1'b1;
                            r_next.ctrl.count = r_reg.rcnt + 8'h01;
                            r_next.scl_oe = 1'b1;
                            r_next.str_cnt = '0;
                            r_next.state = S_RDWAIT;
                        end
                    end
                end
                S_RDWAIT: begin
                    r_next.str_cnt = r_reg.str_cnt + STR_W'(1);
                    if (I_CTRL_RD_VALID || (r_reg.str_cnt == STR_W'(STRETCH_CYC - 2))) begin
                        r_next.shift = I_CTRL_RD_VALID ? I_CTRL_RD_DATA : RD_FILL;
                        r_next.sda_oe = I_CTRL_RD_VALID ? ~I_CTRL_RD_DATA[7] : 1'b0;
                        r_next.state = S_SEND;
                    end
                end
                S_SEND: begin
                    // Data settles one cycle before the stretched clock is let go.
                    r_next.scl_oe = 1'b0;
                    if (scl_fall) begin
                        if (r_reg.bitcnt == 3'h7) begin
                            r_next.sda_oe = 1'b0;
                            r_next.state = S_SACK;
                        end else begin
                            r_next.shift = {r_reg.shift[6:0], 1'b0};
                            r_next.bitcnt = r_reg.bitcnt + 3'h1;
                            r_next.sda_oe = ~r_reg.shift[6];
                        end
                    end
                end
                S_SACK: begin
                    if (scl_rise) begin
                        r_next.state = r_reg.sda_s ? S_IDLE : S_SNXT;
                    end
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Registers.
    // -----------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            r_reg <= REGS_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_data;
        end
    end

    assign O_SCL_OUT = r_reg.scl_o;
    assign O_SCL_OE  = r_reg.scl_oe;
    assign O_SDA_OUT = r_reg.sda_o;
    assign O_SDA_OE  = r_reg.sda_oe;
    assign O_CTRL    = r_reg.ctrl;

    // -----------------------------------------------------------------
    // Assertions.
    // -----------------------------------------------------------------
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_NRST);

    a_no_start_drive: assert property ($rose(r_reg.sda_oe) |-> !r_reg.scl_s)
        else $error("Data line pulled low while clock high.");
    a_stretch_bound: assert property (r_reg.scl_oe |-> r_reg.str_cnt < STR_W'(STRETCH_CYC))
        else $error("Clock stretch held too long.");
    a_timeout_idle: assert property (timeout |=> r_reg.state == S_IDLE && !r_reg.sda_oe
        && !r_reg.scl_oe)
        else $error("Clock low timeout did not return to idle.");
    a_start_restart: assert property (start_det && !timeout |=> r_reg.state == S_RECV
        && r_reg.is_addr && r_reg.bitcnt == 3'h0 && !r_reg.sda_oe)
        else $error("START did not restart the address phase.");
    a_stop_idle: assert property (stop_det && !timeout && !start_det
        |=> r_reg.state == S_IDLE && !r_reg.sda_oe)
        else $error("STOP did not idle the slave.");
    a_no_foreign_ack: assert property (r_reg.state == S_RECV_END && r_reg.is_addr
        && !hit_ctrl && !hit_ee && scl_fall && !start_det && !stop_det && !timeout
        |=> !r_reg.sda_oe)
        else $error("Foreign address acknowledged.");
    a_own_addr_ack: assert property (r_reg.state == S_RECV_END && r_reg.is_addr
        && (hit_ctrl || hit_ee) && scl_fall && !start_det && !stop_det && !timeout
        |=> r_reg.sda_oe ##1 r_reg.sda_oe)
        else $error("Own address not acknowledged.");
    a_ee_store: assert property (mem_we |=> mem[$past(mem_addr)] == $past(mem_data))
        else $error("EEPROM byte not stored.");
    a_block_limit: assert property (r_reg.ctrl.wr_valid |-> r_reg.ctrl.count != 8'h00)
        else $error("Block write count wrapped.");
    a_cmd_first: assert property (r_reg.ctrl.cmd_valid |-> r_reg.ctrl.count == 8'h01)
        else $error("Command code not first byte.");

    c_ee_write: cover property (mem_we ##[1:1000] stop_det);
    c_ctrl_read: cover property (r_reg.ctrl.rd_req ##[1:200] r_reg.state == S_SEND);
    c_timeout: cover property (timeout);
    c_word_write: cover property (r_reg.ctrl.stop && r_reg.ctrl.count == 8'h03);

endmodule // pss_slave

`default_nettype wire

// *** dv/pss_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module pss_host #(
    parameter int unsigned GAP_CYC = 40
) (
    input  wire logic i_clk,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output var  logic o_scl_low,
    output var  logic o_sda_low
);
    int hangs = 0;

    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end

    // ------------------------------------------------------------
    // Bus phases.
    // ------------------------------------------------------------
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic wait_high();
        int k;
        k = 0;
        while (i_scl !== 1'b1 && k < 400) begin
            @(posedge i_clk);
            k++;
        end
        if (k >= 400) hangs++;
    endtask

    task automatic start();
        wt(1);
        o_sda_low <= 1'b1;
        wt(4);
        o_scl_low <= 1'b1;
    endtask

    task automatic rstart();
        wt(2);
        o_sda_low <= 1'b0;
        wt(4);
        o_scl_low <= 1'b0;
        wait_high();
        wt(4);
        o_sda_low <= 1'b1;
        wt(4);
        o_scl_low <= 1'b1;
    endtask

    task automatic stop();
        wt(2);
        o_sda_low <= 1'b1;
        wt(4);
        o_scl_low <= 1'b0;
        wait_high();
        wt(4);
        o_sda_low <= 1'b0;
        wt(GAP_CYC);
    endtask

    task automatic bitx(input logic b, output logic r);
        wt(2);
        o_sda_low <= !b;
        wt(4);
        o_scl_low <= 1'b0;
        wait_high();
        r = i_sda;
        wt(1);
        o_scl_low <= 1'b1;
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask

    task automatic rbyte(input logic ackit, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(!ackit, r);
    endtask
endmodule // pss_host

`default_nettype wire

// *** dv/pss_slave_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module pss_slave_tb;
    import pss_pkg::*;
    localparam int unsigned STR_SIM = 50;
    localparam int unsigned TO_SIM  = 200;
    logic             clk      = 1'b0;
    logic             nrst     = 1'b0;
    logic [2:0]       strap    = 3'h0;
    logic             rd_en    = 1'b0;
    logic             rd_valid = 1'b0;
    logic [7:0]       rd_data  = 8'h00;
    logic             scl_oe;
    logic             sda_oe;
    logic             scl_out;
    logic             sda_out;
    logic             h_scl_low;
    logic             h_sda_low;
    logic             scl_q    = 1'b1;
    logic             sda_oe_q = 1'b0;
    logic             ack;
    logic [7:0]       got;
    pss_ctrl_out_type ctrl;
    wire logic        scl_w = !(h_scl_low | scl_oe);
    wire logic        sda_w = !(h_sda_low | sda_oe);
    int miscompares = 0, n_compared = 0, n_start = 0, n_stop = 0, n_abort = 0;
    int n_cmd = 0, n_wr = 0, oe_run = 0, oe_max = 0, r1_bad = 0;

    pss_slave #(.STRETCH_CYC(STR_SIM), .TIMEOUT_CYC(TO_SIM)) i_pss_slave (
        .I_SYS_CLK(clk), .I_NRST(nrst), .I_SCL(scl_w), .O_SCL_OUT(scl_out), .O_SCL_OE(scl_oe),
        .I_SDA(sda_w), .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .I_ADDR_STRAP_BIT0(strap[0]),
        .I_ADDR_STRAP_BIT1(strap[1]), .I_ADDR_STRAP_BIT2(strap[2]),
        .I_CTRL_RD_VALID(rd_valid), .I_CTRL_RD_DATA(rd_data), .O_CTRL(ctrl));

    pss_host i_pss_host (.i_clk(clk), .i_scl(scl_w), .i_sda(sda_w),
        .o_scl_low(h_scl_low), .o_sda_low(h_sda_low));

    always #12.5 clk = ~clk;

    // ------------------------------------------------------------
    // Read-data responder and event monitor.
    // ------------------------------------------------------------
    always @(posedge clk) begin
        rd_valid <= rd_en && (ctrl.rd_req === 1'b1);
        if (rd_en && ctrl.rd_req === 1'b1) rd_data <= rd_data + 8'h11;
        n_start += (ctrl.start === 1'b1);
        n_stop += (ctrl.stop === 1'b1);
        n_abort += (ctrl.abort === 1'b1);
        n_cmd += (ctrl.cmd_valid === 1'b1);
        n_wr += (ctrl.wr_valid === 1'b1);
        oe_run = (scl_oe === 1'b1) ? oe_run + 1 : 0;
        if (oe_run > oe_max) oe_max = oe_run;
        if (nrst && scl_q && scl_w && sda_oe !== sda_oe_q) r1_bad++;
        scl_q = scl_w;
        sda_oe_q = sda_oe;
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic report_and_stop();
        $display("miscompares=%0d n_compared=%0d", miscompares, n_compared);
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    task automatic t_address();
        int s0;
        for (int s = 0; s < 8; s++) begin
            strap <= s[2:0];
            i_pss_host.wt(6);
            s0 = n_start;
            i_pss_host.start();
            i_pss_host.wbyte(8'hA0 + 8'(2 * s), ack);
            i_pss_host.stop();
            chk({7'h00, ack}, 8'h01);
            i_pss_host.start();
            i_pss_host.wbyte(8'hB0 + 8'(2 * s), ack);
            i_pss_host.stop();
            chk({7'h00, ack}, 8'h01);
            chk(8'(n_start - s0), 8'h01);
            i_pss_host.start();
            i_pss_host.wbyte(8'hA0 + 8'(2 * ((s + 1) % 8)), ack);
            i_pss_host.stop();
            chk({7'h00, ack}, 8'h00);
        end
    endtask

    task automatic t_eeprom();
        logic [7:0] loc [2];
        loc = '{8'h05, 8'hFF};
        for (int i = 0; i < 2; i++) begin
            i_pss_host.start();
            i_pss_host.wbyte(8'hAE, ack);
            i_pss_host.wbyte(loc[i], ack);
            i_pss_host.wbyte(loc[i] ^ 8'h39, ack);
            i_pss_host.stop();
            chk({7'h00, ack}, 8'h01);
        end
        for (int i = 0; i < 2; i++) begin
            i_pss_host.start();
            i_pss_host.wbyte(8'hAE, ack);
            i_pss_host.wbyte(loc[i], ack);
            i_pss_host.rstart();
            i_pss_host.wbyte(8'hAF, ack);
            i_pss_host.rbyte(1'b0, got);
            i_pss_host.stop();
            chk(got, loc[i] ^ 8'h39);
        end
    endtask

    task automatic t_ctrl_write();
        int c0, w0, p0;
        for (int n = 0; n < 3; n++) begin
            c0 = n_cmd;
            w0 = n_wr;
            p0 = n_stop;
            i_pss_host.start();
            i_pss_host.wbyte(8'hBE, ack);
            i_pss_host.wbyte(8'h21, ack);
            for (int k = 0; k < n; k++) i_pss_host.wbyte(8'h50 + 8'(k), ack);
            i_pss_host.stop();
            chk({7'h00, ack}, 8'h01);
            chk(8'(n_cmd - c0), 8'h01);
            chk(ctrl.cmd, 8'h21);
            chk(8'(n_wr - w0), 8'(n));
            chk(ctrl.count, 8'(n + 1));
            chk(8'(n_stop - p0), 8'h01);
        end
        chk(ctrl.wr_data, 8'h51);
    endtask

    task automatic t_ctrl_read();
        for (int p = 0; p < 2; p++) begin
            rd_en <= (p == 0);
            i_pss_host.start();
            i_pss_host.wbyte(8'hBE, ack);
            i_pss_host.wbyte(8'h8B, ack);
            i_pss_host.rstart();
            i_pss_host.wbyte(8'hBF, ack);
            chk({7'h00, ack}, 8'h01);
            i_pss_host.rbyte(p == 0, got);
            chk(got, (p == 0) ? 8'h11 : 8'hFF);
            if (p == 0) i_pss_host.rbyte(1'b0, got);
            if (p == 0) chk(got, 8'h22);
            i_pss_host.stop();
            chk(ctrl.cmd, 8'h8B);
            chk({7'h00, ctrl.is_read}, 8'h01);
            chk(ctrl.count, (p == 0) ? 8'h02 : 8'h01);
        end
        chk({7'h00, oe_max <= STR_SIM + 1}, 8'h01);
    endtask

    task automatic t_timeout();
        int a0;
        a0 = n_abort;
        i_pss_host.start();
        i_pss_host.wbyte(8'hBE, ack);
        i_pss_host.wt(TO_SIM + 40);
        chk({6'h00, sda_oe, scl_oe}, 8'h00);
        chk(8'(n_abort - a0), 8'h01);
        i_pss_host.stop();
    endtask

    task automatic t_stray();
        int a0, c0;
        a0 = n_abort;
        c0 = n_cmd;
        i_pss_host.start();
        i_pss_host.wbyte(8'hBE, ack);
        for (int k = 0; k < 4; k++) i_pss_host.bitx(1'b1, got[0]);
        i_pss_host.stop();
        chk(8'(n_abort - a0), 8'h01);
        chk(8'(n_cmd - c0), 8'h00);
        chk({7'h00, sda_oe}, 8'h00);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_address();
        t_eeprom();
        t_ctrl_write();
        t_ctrl_read();
        t_timeout();
        t_stray();
        chk(8'(r1_bad), 8'h00);
        chk(8'(i_pss_host.hangs), 8'h00);
        chk({6'h00, scl_out, sda_out}, 8'h00);
        report_and_stop();
    end

    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
endmodule // pss_slave_tb

`default_nettype wire
